// ---- rtl/udp_ctrl.sv ----
// Behaviour
// - Host resume on the port sets the bus resume status bit.
// - Rising edge on local resume input while suspended raises external resume.
// - With remote wake allowed, a local resume request while suspended drives resume onto the bus.
// - Each start-of-frame token sets the frame start status bit.
// - End of a bus reset sets the reset done status bit.
// - Host resume or reset sets wakeup, held until software clears it.
// - Writing ones to clear register bits 8..13 clears those status bits.
// - Endpoint reset bit holds FIFO pointers and byte count at zero.
// - Endpoint reset returns the data toggle to DATA0.
// - Host ack of IN sets in-done; write 0 clears, 1 ignored.
// - OUT packet into bank 0 sets bank0 flag; software writes 0 to release.
// - Ping-pong endpoints alternate into bank 1 and set bank1 flag.
// - Valid setup sets setup flag; OUT refused until software clears it.
// - Host ack of stall sets stall-acked flag until software writes 0.
// - Isochronous endpoints use the same bit as CRC error flag.
// - Transmit ready reads 1 until payload sent; then device clears it.
// - Writing 1 to force stall makes the endpoint answer with STALL.
// - Control direction 0 allows data OUT, 1 enables data IN.
// - Direction set before setup clear; status stage reverses automatically.
// - No bus activity for 3 ms sets suspend status and enters suspend.
// - Endpoint interrupt status stays set while any causing flag is set.
// - Endpoint FIFO bytes move through an 8-bit data port, one per access.
`timescale 1ns/1ps
`include "udp_map.svh"
module udp_ctrl
  import udp_pkg::*;
#(
  parameter int NUM_EP    = 8,
  parameter int FIFO_DEPTH = 64,
  parameter int SUSPEND_CYCLES = `UDP_SUSPEND_US * `UDP_CLK_MHZ
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire udp_bus_ev_t bus_ev,
  input  wire udp_ep_ev_t  ep_ev,
  input  wire logic        ep_ev_valid,
  input  wire logic [2:0]  hs_ep,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_byte_valid,
  input  wire logic        tx_byte_take,
  output logic [7:0]       tx_byte,
  output udp_hs_t          hs_answer,
  output logic             status_dir_in,
  output logic             send_resume_bus,
  output logic             suspended,
  input  wire logic        local_resume_req,
  output logic             irq
);
  localparam int AW = $clog2(FIFO_DEPTH);

  initial
  begin
    if (NUM_EP < 1 || NUM_EP > 8) $error("NUM_EP must be 1 to 8");
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 1024) $error("FIFO_DEPTH out of range");
  end

  // Status bits 13:8 hold bus events; endpoint bits are derived.
  logic [5:0]        ev_status;
  logic [NUM_EP-1:0] ep_reset;
  logic              remote_wake_allow;
  logic [13:0]       irq_mask;
  logic [7:0]        csr_flags [NUM_EP];
  logic [NUM_EP-1:0] toggle;
  logic [NUM_EP-1:0] ep_active;
  logic [NUM_EP-1:0] pingpong;
  logic [NUM_EP-1:0] iso;
  logic [NUM_EP-1:0] next_bank;
  logic [10:0]       count [NUM_EP];
  logic [AW-1:0]     rd_ptr [NUM_EP];
  logic [AW-1:0]     wr_ptr [NUM_EP];
  logic [7:0]        mem [NUM_EP][FIFO_DEPTH];
  logic [31:0]       susp_cnt;
  logic [1:0]        res_sync;
  logic              res_prev;
  logic              stage_status;

  // Decode helpers used by the register and FIFO paths.
  function automatic logic is_ep_reg(input logic [11:0] a, input logic [11:0] base);
    is_ep_reg = (a[11:5] == base[11:5]) && (a[1:0] == 2'h0) && (int'(a[4:2]) < NUM_EP);
  endfunction : is_ep_reg

  function automatic logic [7:0] ep_pending(input logic [7:0] f);
    ep_pending = {7'h00, f[`UDP_CSR_IN_DONE] | f[`UDP_CSR_BANK0] | f[`UDP_CSR_SETUP]
                  | f[`UDP_CSR_STALL_ACK] | f[`UDP_CSR_BANK1]};
  endfunction : ep_pending

  logic       wr_acc;
  logic       rd_acc;
  logic [2:0] sel_ep;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign sel_ep = paddr[4:2];

  // The local resume request is asynchronous, so it is synchronised first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_sync <= 2'h0;
      res_prev <= 1'b0;
    end
    else
    begin
      res_sync <= {res_sync[0], local_resume_req};
      res_prev <= res_sync[1];
    end
  end
  logic local_rise;
  assign local_rise = res_sync[1] && !res_prev;

  // Idle counter; any bus activity restarts it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      susp_cnt  <= 32'h0;
      suspended <= 1'b0;
    end
    else if (bus_ev.activity || bus_ev.resume || bus_ev.reset_done)
    begin
      susp_cnt  <= 32'h0;
      suspended <= 1'b0;
    end
    else if (susp_cnt == 32'(SUSPEND_CYCLES - 1))
      suspended <= 1'b1;
    else if (!suspended)
      susp_cnt <= susp_cnt + 32'h1;
  end

  // Remote wakeup drives resume only while suspended and permitted.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      send_resume_bus <= 1'b0;
    else if (suspended && local_rise && remote_wake_allow)
      send_resume_bus <= 1'b1;
    else if (!suspended)
      send_resume_bus <= 1'b0;
  end

  // Bus event status; a set in the same cycle as a clear wins.
  logic [5:0] ev_set;
  logic [5:0] ev_clr;
  assign ev_set = {bus_ev.resume || bus_ev.reset_done,
                   bus_ev.reset_done,
                   bus_ev.sof,
                   suspended && local_rise,
                   bus_ev.resume,
                   !suspended && susp_cnt == 32'(SUSPEND_CYCLES - 1)};
  assign ev_clr = (wr_acc && paddr == `UDP_OFS_CLEAR) ? pwdata[13:8] : 6'h00;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_status <= 6'h00;
    else
      ev_status <= (ev_status & ~ev_clr) | ev_set;
  end

  // Configuration registers written by software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ep_reset          <= '0;
      remote_wake_allow <= 1'b0;
      irq_mask          <= 14'h0200;
      ep_active         <= '0;
      pingpong          <= '0;
      iso               <= '0;
    end
    else if (wr_acc)
    begin
      if (paddr == `UDP_OFS_FIFO_RESET)
        ep_reset <= pwdata[NUM_EP-1:0];
      if (paddr == `UDP_OFS_CONFIG)
      begin
        remote_wake_allow <= pwdata[0];
        pingpong          <= pwdata[8 +: NUM_EP];
        iso               <= pwdata[16 +: NUM_EP];
      end
      if (paddr == `UDP_OFS_MASK)
        irq_mask <= pwdata[13:0];
      if (is_ep_reg(paddr, `UDP_OFS_CSR_BASE))
        ep_active[sel_ep] <= pwdata[`UDP_CSR_ACTIVE];
    end
  end

  // Endpoint flags: hardware sets win over software clears in one cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_EP; i++)
        csr_flags[i] <= 8'h00;
      toggle    <= '0;
      next_bank <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_EP; i++)
      begin
        logic [7:0] f;
        f = csr_flags[i];
        if (wr_acc && is_ep_reg(paddr, `UDP_OFS_CSR_BASE) && sel_ep == 3'(i))
        begin
          f[`UDP_CSR_IN_DONE]   = f[`UDP_CSR_IN_DONE] & pwdata[`UDP_CSR_IN_DONE];
          f[`UDP_CSR_BANK0]     = f[`UDP_CSR_BANK0] & pwdata[`UDP_CSR_BANK0];
          f[`UDP_CSR_BANK1]     = f[`UDP_CSR_BANK1] & pwdata[`UDP_CSR_BANK1];
          f[`UDP_CSR_SETUP]     = f[`UDP_CSR_SETUP] & pwdata[`UDP_CSR_SETUP];
          f[`UDP_CSR_STALL_ACK] = f[`UDP_CSR_STALL_ACK] & pwdata[`UDP_CSR_STALL_ACK];
          f[`UDP_CSR_TX_READY]  = f[`UDP_CSR_TX_READY] | pwdata[`UDP_CSR_TX_READY];
          f[`UDP_CSR_FORCE_STALL] = f[`UDP_CSR_FORCE_STALL]
                                    | pwdata[`UDP_CSR_FORCE_STALL];
          f[`UDP_CSR_DIR]       = pwdata[`UDP_CSR_DIR];
        end
        if (ep_ev_valid && ep_ev.ep == 3'(i))
        begin
          if (ep_ev.in_ack)
          begin
            f[`UDP_CSR_TX_READY] = 1'b0;
            f[`UDP_CSR_IN_DONE]  = 1'b1;
          end
          if (ep_ev.setup_rx)
            f[`UDP_CSR_SETUP] = 1'b1;
          if (ep_ev.out_rx && !(pingpong[i] && next_bank[i]))
            f[`UDP_CSR_BANK0] = 1'b1;
          if (ep_ev.out_rx && pingpong[i] && next_bank[i])
            f[`UDP_CSR_BANK1] = 1'b1;
          if ((ep_ev.stall_ack && !iso[i]) || (ep_ev.crc_err && iso[i]))
            f[`UDP_CSR_STALL_ACK] = 1'b1;
        end
        csr_flags[i] <= f;
        if (ep_reset[i])
          toggle[i] <= 1'b0;
        else if (ep_ev_valid && ep_ev.ep == 3'(i) && (ep_ev.out_rx || ep_ev.in_ack))
          toggle[i] <= ~ep_ev.toggle;
        if (ep_reset[i])
          next_bank[i] <= 1'b0;
        else if (ep_ev_valid && ep_ev.ep == 3'(i) && ep_ev.out_rx && pingpong[i])
          next_bank[i] <= ~next_bank[i];
      end
    end
  end

  // FIFO pointers; held at zero while the endpoint reset bit is set.
  logic fdr_wr;
  logic fdr_rd;
  assign fdr_wr = wr_acc && is_ep_reg(paddr, `UDP_OFS_FDR_BASE);
  assign fdr_rd = rd_acc && is_ep_reg(paddr, `UDP_OFS_FDR_BASE);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NUM_EP; i++)
      begin
        rd_ptr[i] <= '0;
        wr_ptr[i] <= '0;
        count[i]  <= 11'h000;
      end
    else
      for (int i = 0; i < NUM_EP; i++)
      begin
        if (ep_reset[i])
        begin
          rd_ptr[i] <= '0;
          wr_ptr[i] <= '0;
          count[i]  <= 11'h000;
        end
        else
        begin
          if ((fdr_wr && sel_ep == 3'(i)) || (rx_byte_valid && hs_ep == 3'(i)))
            wr_ptr[i] <= wr_ptr[i] + AW'(1);
          if ((fdr_rd && sel_ep == 3'(i)) || (tx_byte_take && hs_ep == 3'(i)))
            rd_ptr[i] <= rd_ptr[i] + AW'(1);
          if (ep_ev_valid && ep_ev.ep == 3'(i) && (ep_ev.out_rx || ep_ev.setup_rx))
            count[i] <= ep_ev.count;
          else if (fdr_rd && sel_ep == 3'(i) && count[i] != 11'h000)
            count[i] <= count[i] - 11'h001;
        end
      end
  end

  // FIFO storage shared by software pushes and received bytes.
  always_ff @(posedge pclk)
  begin
    if (rx_byte_valid && !csr_flags[hs_ep][`UDP_CSR_SETUP])
      mem[hs_ep][wr_ptr[hs_ep]] <= rx_byte;
    else if (fdr_wr)
      mem[sel_ep][wr_ptr[sel_ep]] <= pwdata[7:0];
  end

  // Handshake answer for the endpoint the link engine is serving.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_answer     <= UDP_HS_NAK;
      status_dir_in <= 1'b0;
      stage_status  <= 1'b0;
      tx_byte       <= 8'h00;
    end
    else
    begin
      tx_byte <= mem[hs_ep][rd_ptr[hs_ep]];
      if (csr_flags[hs_ep][`UDP_CSR_FORCE_STALL])
        hs_answer <= UDP_HS_STALL;
      else if (csr_flags[hs_ep][`UDP_CSR_SETUP])
        hs_answer <= UDP_HS_NAK;
      else
        hs_answer <= UDP_HS_ACK;
      // Status stage runs opposite to the data stage without software help.
      if (ep_ev_valid && ep_ev.setup_rx)
        stage_status <= 1'b0;
      else if (ep_ev_valid && (ep_ev.in_ack || ep_ev.out_rx))
        stage_status <= 1'b1;
      status_dir_in <= csr_flags[hs_ep][`UDP_CSR_DIR] ^ stage_status;
    end
  end

  // Endpoint status bits follow their flags, so they stay until cleared.
  logic [NUM_EP-1:0] ep_irq;
  always_comb
  begin
    for (int i = 0; i < NUM_EP; i++)
      ep_irq[i] = |ep_pending(csr_flags[i]);
  end
  logic [13:0] status_all;
  assign status_all = {ev_status, 8'(ep_irq)};

  // Interrupt output registered so it comes straight from a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_all & irq_mask);
  end

  // APB read data; zero-wait answer, unmapped reads give zero and an error.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == `UDP_OFS_STATUS)
          prdata <= {18'h0, status_all};
        else if (paddr == `UDP_OFS_FIFO_RESET)
          prdata <= 32'(ep_reset);
        else if (paddr == `UDP_OFS_CONFIG)
          prdata <= {8'h0, 8'(iso), 8'(pingpong), 7'h0, remote_wake_allow};
        else if (paddr == `UDP_OFS_MASK)
          prdata <= {18'h0, irq_mask};
        else if (is_ep_reg(paddr, `UDP_OFS_CSR_BASE))
          prdata <= {5'h0, count[sel_ep], ep_active[sel_ep], 3'h0, toggle[sel_ep], 3'h0,
                     csr_flags[sel_ep] & 8'hdf};
        else if (is_ep_reg(paddr, `UDP_OFS_FDR_BASE))
          prdata <= {24'h0, mem[sel_ep][rd_ptr[sel_ep]]};
        else if (paddr != `UDP_OFS_CLEAR)
          pslverr <= 1'b1;
      end
      else if (psel && !penable && pwrite)
        pslverr <= !(paddr == `UDP_OFS_CLEAR || paddr == `UDP_OFS_FIFO_RESET
                     || paddr == `UDP_OFS_CONFIG || paddr == `UDP_OFS_MASK
                     || is_ep_reg(paddr, `UDP_OFS_CSR_BASE)
                     || is_ep_reg(paddr, `UDP_OFS_FDR_BASE));
    end
  end
endmodule : udp_ctrl

// ---- rtl/udp_map.svh ----
`ifndef UDP_MAP_SVH
`define UDP_MAP_SVH
// Register byte offsets.
`define UDP_OFS_STATUS      12'h000
`define UDP_OFS_CLEAR       12'h004
`define UDP_OFS_FIFO_RESET  12'h008
`define UDP_OFS_CONFIG      12'h00c
`define UDP_OFS_MASK        12'h010
`define UDP_OFS_CSR_BASE    12'h040
`define UDP_OFS_FDR_BASE    12'h080
// Status bit positions.
`define UDP_BIT_SUSPEND     8
`define UDP_BIT_RESUME      9
`define UDP_BIT_EXT_RESUME  10
`define UDP_BIT_SOF         11
`define UDP_BIT_RESET_DONE  12
`define UDP_BIT_WAKEUP      13
// Control/status bit positions.
`define UDP_CSR_IN_DONE     0
`define UDP_CSR_BANK0       1
`define UDP_CSR_SETUP       2
`define UDP_CSR_STALL_ACK   3
`define UDP_CSR_TX_READY    4
`define UDP_CSR_FORCE_STALL 5
`define UDP_CSR_BANK1       6
`define UDP_CSR_DIR         7
`define UDP_CSR_TOGGLE      11
`define UDP_CSR_ACTIVE      15
`define UDP_CSR_COUNT_LSB   16
// Idle time before suspend.
`define UDP_SUSPEND_US      3000
`define UDP_CLK_MHZ         20
`endif

// ---- rtl/udp_pkg.sv ----
package udp_pkg;
  // Bus events seen by the link side, one-cycle pulses.
  typedef struct packed {
    logic sof;
    logic resume;
    logic reset_done;
    logic activity;
  } udp_bus_ev_t;
  // Per-endpoint transaction events from the link engine.
  typedef struct packed {
    logic [2:0]  ep;
    logic        setup_rx;
    logic        out_rx;
    logic        in_ack;
    logic        stall_ack;
    logic        crc_err;
    logic        toggle;
    logic [10:0] count;
  } udp_ep_ev_t;
  // Link-side view of the endpoint flags.
  typedef enum logic [1:0] {UDP_HS_ACK, UDP_HS_NAK, UDP_HS_STALL} udp_hs_t;
  typedef enum logic [1:0] {UDP_LINK_RUN, UDP_LINK_SUSP, UDP_LINK_WAKE} udp_link_t;
endpackage : udp_pkg

// ---- verification/udp_chk.sv ----
`timescale 1ns/1ps
module udp_chk
  import udp_pkg::*;
#(
  parameter int SUSPEND_CYCLES = 50
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire udp_bus_ev_t bus_ev,
  input wire logic [2:0]  hs_ep,
  input wire udp_hs_t     hs_answer,
  input wire logic        send_resume_bus,
  input wire logic        suspended,
  input wire logic        local_resume_req,
  input wire logic        irq
);
  logic       wacc;
  logic       racc;
  logic [3:0] st;
  logic [1:0] quiet;
  int         idle;
  logic [7:0] stall;
  logic       wake_ok;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only a completed access moves state or carries read data.
  assign wacc = psel && penable && pready && pwrite;
  assign racc = psel && penable && pready && !pwrite;
  // Shadow of wakeup, reset done, frame start and resume; clears win here, so reads
  // are judged only once events and clears have been quiet for a while.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      st <= 4'h0;
    else
      st <= (st | {bus_ev.resume | bus_ev.reset_done, bus_ev.reset_done, bus_ev.sof,
        bus_ev.resume}) & ~((wacc && paddr == 12'h004) ? {pwdata[13:11], pwdata[9]} : 4'h0);
  // Quiet time since the last event or clear write.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      quiet <= 2'h0;
    else if (bus_ev != '0 || (wacc && paddr == 12'h004))
      quiet <= 2'h0;
    else if (quiet != 2'h3)
      quiet <= quiet + 2'h1;
  // Idle cycles since bus activity, saturating far above any suspend span.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      idle <= 0;
    else if (bus_ev.activity)
      idle <= 0;
    else if (idle < 1000000)
      idle <= idle + 1;
  // Force stall is sticky until reset; remote wake follows the last config write.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      stall   <= 8'h0;
      wake_ok <= 1'b0;
    end
    else if (wacc)
    begin
      if (paddr[11:5] == 7'h02 && pwdata[5])
        stall[paddr[4:2]] <= 1'b1;
      if (paddr == 12'h00c)
        wake_ok <= pwdata[0];
    end
  property p_status;
    racc && paddr == 12'h000 && quiet == 2'h3 |-> {prdata[13:11], prdata[9]} == st;
  endproperty
  a_status: assert property (p_status)
    else $error("status bits disagree with bus events");
  property p_irq;
    bus_ev.resume |-> ##[1:3] irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("resume did not raise irq");
  property p_susp_time;
    $rose(suspended) |-> idle >= SUSPEND_CYCLES - 2 && idle <= SUSPEND_CYCLES + 2;
  endproperty
  a_susp_time: assert property (p_susp_time)
    else $error("suspend entered at wrong idle time");
  property p_susp_early;
    !suspended && idle < SUSPEND_CYCLES - 2 |=> !suspended;
  endproperty
  a_susp_early: assert property (p_susp_early)
    else $error("suspend entered too early");
  property p_stall;
    stall[hs_ep] ##1 (stall[hs_ep] && $stable(hs_ep)) |=> hs_answer == UDP_HS_STALL;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stalled endpoint not answered with stall");
  property p_wake_gate;
    $rose(send_resume_bus) |-> wake_ok;
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("resume driven without remote wake");
  property p_wake_send;
    suspended && wake_ok && $rose(local_resume_req) |-> ##[1:8] send_resume_bus;
  endproperty
  a_wake_send: assert property (p_wake_send)
    else $error("local request did not drive resume");
  property p_fifo_byte;
    racc && paddr[11:5] == 7'h04 |-> prdata[31:8] == 24'h0;
  endproperty
  a_fifo_byte: assert property (p_fifo_byte)
    else $error("fifo port read wider than a byte");
endmodule : udp_chk

bind udp_ctrl udp_chk #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) udp_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .bus_ev(bus_ev),
  .hs_ep(hs_ep), .hs_answer(hs_answer), .send_resume_bus(send_resume_bus),
  .suspended(suspended), .local_resume_req(local_resume_req), .irq(irq));

// ---- verification/udp_lm.sv ----
`timescale 1ns/1ps
module udp_lm
  import udp_pkg::*;
(
  input  wire logic   pclk,
  output udp_bus_ev_t bus_ev,
  output udp_ep_ev_t  ep_ev,
  output logic        ep_ev_valid,
  output logic        local_resume_req
);
  // Idle at time zero; the record holds junk while unqualified.
  initial
  begin
    bus_ev = '0;
    ep_ev = '1;
    ep_ev_valid = 1'b0;
    local_resume_req = 1'b0;
  end
  // One host event; each one also counts as bus activity.
  task automatic bus(input logic s, input logic r, input logic d);
    @(posedge pclk);
    bus_ev <= {s, r, d, 1'b1};
    @(posedge pclk);
    bus_ev <= '0;
  endtask : bus
  // One transaction; the record is scrambled once valid drops.
  task automatic ep_evt(input logic [2:0] n, input logic [3:0] f, input logic [10:0] c);
    @(posedge pclk);
    ep_ev <= {n, f[2], f[1], f[0], f[3], 1'b0, 1'b0, c};
    ep_ev_valid <= 1'b1;
    bus_ev <= 4'h1;
    @(posedge pclk);
    ep_ev <= ~ep_ev;
    ep_ev_valid <= 1'b0;
    bus_ev <= '0;
  endtask : ep_evt
  // A clean rising edge held long enough for the synchroniser.
  task automatic wake();
    @(posedge pclk);
    local_resume_req <= 1'b1;
    repeat (8) @(posedge pclk);
    local_resume_req <= 1'b0;
  endtask : wake
endmodule : udp_lm

// ---- verification/test_usb_device_port_endpoint_ctrl.sv ----
`timescale 1ns/1ps
module test_usb_device_port_endpoint_ctrl
  import udp_pkg::*;
();
  localparam int SUSP = 400;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [2:0]  hs_ep = 0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  udp_bus_ev_t bus_ev;
  udp_ep_ev_t  ep_ev;
  logic        ep_ev_valid;
  logic        local_resume_req;
  udp_hs_t     hs_answer;
  logic        send_resume_bus;
  logic        suspended;
  logic        irq;
  int          err_count;
  int          checks;
  int          est;
  int          fl[8];
  // Free-running 20 MHz clock.
  always #25 pclk = ~pclk;
  udp_ctrl #(.SUSPEND_CYCLES(SUSP)) udp_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bus_ev(bus_ev), .ep_ev(ep_ev), .ep_ev_valid(ep_ev_valid), .hs_ep(hs_ep),
    .rx_byte(8'h00), .rx_byte_valid(1'b0), .tx_byte_take(1'b0), .tx_byte(),
    .hs_answer(hs_answer), .status_dir_in(), .send_resume_bus(send_resume_bus),
    .suspended(suspended), .local_resume_req(local_resume_req), .irq(irq));
  udp_lm udp_lm_inst (.pclk(pclk), .bus_ev(bus_ev), .ep_ev(ep_ev),
    .ep_ev_valid(ep_ev_valid), .local_resume_req(local_resume_req));
  task automatic complete_run();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp
  // One APB transfer, held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    cmp("pready", 1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  // Status is the event bits plus a pending bit for each endpoint with a flag up.
  task automatic chk_status(input int msk);
    logic [31:0] r;
    logic        e;
    int          x;
    x = est;
    for (int i = 0; i < 8; i++)
      if (fl[i] != 0)
        x |= 1 << i;
    apb(1'b0, 12'h000, 32'h0, r, e);
    cmp("status", x & msk, r & msk);
    cmp("irq", (est >> 9) & 1, {31'h0, irq});
  endtask : chk_status
  // Cut a hung run short.
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [11:0] ca;
    int          ep;
    int          c;
    err_count = 0;
    checks = 0;
    est = 0;
    foreach (fl[i]) fl[i] = 0;
    void'($urandom(32'he18dce44));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk_status(32'h3eff);
    // Host events, then a clear of zeros and a clear of ones.
    for (int k = 0; k < 3; k++)
    begin
      udp_lm_inst.bus(k == 0, k == 1, k == 2);
      est |= (k == 0) ? 'h800 : (k == 1) ? 'h2200 : 'h3000;
      chk_status(32'h3eff);
    end
    wr(12'h004, 32'h0);
    chk_status(32'h3eff);
    wr(12'h004, 32'h3e00);
    est = 0;
    chk_status(32'h3eff);
    // Raise all four flags on one endpoint, then clear them one by one.
    ep = $urandom_range(7);
    ca = 12'h040 + 12'(4 * ep);
    wr(ca, 32'h8000);
    for (int b = 0; b < 4; b++)
    begin
      c = $urandom_range(64, 1);
      udp_lm_inst.ep_evt(3'(ep), 4'(1 << b), 11'(c));
      fl[ep] |= 1 << b;
      apb(1'b0, ca, 32'h0, r, e);
      cmp("csr flags", fl[ep], r & 32'h4f);
      if (b == 1)
        cmp("rx count", c, {21'h0, r[26:16]});
      chk_status(32'h3eff);
    end
    hs_ep <= 3'(ep);
    repeat (3) @(posedge pclk);
    cmp("answer", 32'(UDP_HS_NAK), {30'h0, hs_answer});
    for (int b = 0; b < 4; b++)
    begin
      wr(ca, 32'h804f & ~(32'h1 << b));
      fl[ep] &= ~(1 << b);
      apb(1'b0, ca, 32'h0, r, e);
      cmp("csr flags", fl[ep], r & 32'h4f);
    end
    chk_status(32'h3eff);
    // Ping-pong reception, then an endpoint reset.
    wr(12'h00c, 32'h100 << ep);
    c = $urandom_range(64, 1);
    udp_lm_inst.ep_evt(3'(ep), 4'h2, 11'(c));
    udp_lm_inst.ep_evt(3'(ep), 4'h2, 11'(c));
    fl[ep] = 'h42;
    apb(1'b0, ca, 32'h0, r, e);
    cmp("csr flags", fl[ep], r & 32'h4f);
    cmp("toggle", 1, {31'h0, r[11]});
    wr(12'h008, 32'h1 << ep);
    apb(1'b0, ca, 32'h0, r, e);
    cmp("csr flags", fl[ep], r & 32'h4f);
    cmp("rx count", 0, {21'h0, r[26:16]});
    cmp("toggle", 0, {31'h0, r[11]});
    wr(12'h008, 32'h0);
    // Software arms a payload; the host's acknowledgement clears ready and sets in-done.
    wr(ca, 32'h8010);
    apb(1'b0, ca, 32'h0, r, e);
    cmp("tx ready", 32'h10, r & 32'h5f);
    udp_lm_inst.ep_evt(3'(ep), 4'h1, 11'h001);
    apb(1'b0, ca, 32'h0, r, e);
    cmp("tx ready", 32'h01, r & 32'h5f);
    // Force stall reads back as zero and turns the answer to stall.
    wr(ca, 32'h8020);
    fl[ep] = 0;
    apb(1'b0, ca, 32'h0, r, e);
    cmp("force stall", 0, {31'h0, r[5]});
    repeat (3) @(posedge pclk);
    cmp("answer", 32'(UDP_HS_STALL), {30'h0, hs_answer});
    apb(1'b0, 12'h0fc, 32'h0, r, e);
    cmp("slverr", 1, {31'h0, e});
    // Idle bus into suspend, then a local wake with remote wake allowed.
    wr(12'h004, 32'h3f00);
    udp_lm_inst.bus(1'b0, 1'b0, 1'b0);
    repeat (SUSP + 10) @(posedge pclk);
    cmp("suspended", 1, {31'h0, suspended});
    est = 'h100;
    chk_status(32'h3fff);
    wr(12'h00c, 32'h1);
    udp_lm_inst.wake();
    c = 0;
    while (send_resume_bus !== 1'b1 && c < 20)
    begin
      @(posedge pclk);
      c++;
    end
    cmp("resume drive", 1, {31'h0, send_resume_bus});
    est |= 'h400;
    chk_status(32'h3fff);
    udp_lm_inst.bus(1'b0, 1'b1, 1'b0);
    complete_run();
  end
endmodule : test_usb_device_port_endpoint_ctrl
